// ### verilog/dac5_pkg.sv
// Package with register map, field layout and encodings of the 5-bit converter control
package dac5_pkg;
	// ******************************
	// Register map
	// ******************************
	localparam logic [1:0] ADDR_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_LEVEL = 2'h1;
	localparam logic [1:0] ADDR_PIN = 2'h2;
	localparam logic [1:0] ADDR_STATUS = 2'h3;

	// ******************************
	// Field positions
	// ******************************
	localparam int BIT_ENABLE = 7;
	localparam int BIT_PIN_OE = 5;
	localparam int BIT_PSS_HI = 3;
	localparam int BIT_PSS_LO = 2;
	localparam int BIT_NSS = 0;
	localparam int LEVEL_WIDTH = 5;
	localparam int TAP_COUNT = 32;

	localparam logic [7:0] CONTROL_MASK = 8'hAD;
	localparam logic [7:0] LEVEL_MASK = 8'h1F;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [4:0] LEVEL_RESET = 5'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// ******************************
	// Source selections
	// ******************************
	typedef enum logic [1:0] {
		POS_SUPPLY = 2'h0,
		POS_REF_PIN = 2'h1,
		POS_FIXED_REF = 2'h2,
		POS_RESERVED = 2'h3
	} pos_source_t;

	typedef enum logic {
		NEG_GROUND = 1'h0,
		NEG_REF_PIN = 1'h1
	} neg_source_t;
endpackage : dac5_pkg

// ### verilog/dac5_if.sv
// Interface carrying ladder and pin-override controls between the register block and the switch driver
`timescale 1ns/1ps
interface dac5_if;
	logic enable;
	logic pin_oe;
	logic [1:0] pss;
	logic negative_source_select;
	logic [4:0] level;

	modport regs (output enable, output pin_oe, output pss, output negative_source_select, output level);
	modport drive (input enable, input pin_oe, input pss, input negative_source_select, input level);
endinterface : dac5_if

// ### verilog/dac5_switch.sv
// Registered decoder of ladder tap, source switches and pin connection
`timescale 1ns/1ps
module dac5_switch
	import dac5_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	dac5_if.drive ctl,
	output logic [31:0] tap_sel_o,
	output logic [2:0] pos_sel_o,
	output logic [1:0] neg_sel_o,
	output logic ladder_on_o,
	output logic pin_connect_o,
	output logic internal_route_o
);
	import dac5_pkg::*;

	logic [31:0] next_tap;
	logic [2:0] next_pos;
	logic [1:0] next_neg;

	always_comb begin
		next_tap = '0;
		next_pos = '0;
		next_neg = '0;
		if (ctl.enable) begin
			next_tap[ctl.level] = 1'b1;
			case (pos_source_t'(ctl.pss))
				POS_SUPPLY: next_pos = 3'h1;
				POS_REF_PIN: next_pos = 3'h2;
				POS_FIXED_REF: next_pos = 3'h4;
				default: next_pos = 3'h0;
			endcase
			next_neg = (ctl.negative_source_select == NEG_REF_PIN) ? 2'h2 : 2'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tap_sel_o <= '0;
			pos_sel_o <= '0;
			neg_sel_o <= '0;
			ladder_on_o <= 1'b0;
			pin_connect_o <= 1'b0;
			internal_route_o <= 1'b0;
		end else begin
			tap_sel_o <= next_tap;
			pos_sel_o <= next_pos;
			neg_sel_o <= next_neg;
			ladder_on_o <= ctl.enable;
			pin_connect_o <= ctl.pin_oe;
			internal_route_o <= ctl.enable;
		end
	end
endmodule : dac5_switch

// ### verilog/dac5_ctrl.sv
// Top of the 5-bit converter control: registers, pin override and ladder switching
`timescale 1ns/1ps
// Behaviour
// - Converter active only while enable set
// - Thirty-two levels from five-bit level field
// - Tap index equals the level code
// - Selectable positive and negative ladder ends
// - Output routed internally regardless of pin
// - Pin output enable connects voltage to pin
// - Pin enable forces driver and detector off
// - Pin read returns zero while pin analog
// - Positive select decode, code three reserved
// - Negative select: one pin, zero ground
// - Reset disables, disconnects, clears level
// - Sleep and wakeup keep control contents
module dac5_ctrl
	import dac5_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic port_out_i,
	input wire logic port_drive_i,
	input wire logic port_detect_en_i,
	input wire logic pin_in_i,
	input wire logic sleep_i,
	output logic pin_out_o,
	output logic pin_oe_o,
	output logic pin_detect_en_o,
	output logic [31:0] tap_sel_o,
	output logic [2:0] pos_sel_o,
	output logic [1:0] neg_sel_o,
	output logic ladder_on_o,
	output logic pin_connect_o,
	output logic internal_route_o
);
	import dac5_pkg::*;

	// ******************************
	// Registers
	// ******************************
	logic [7:0] control;
	logic [4:0] level;
	logic [7:0] next_control;
	logic [4:0] next_level;
	logic [7:0] next_rdata;
	logic pin_meta;
	logic pin_sync;
	logic next_pin_out;
	logic next_pin_oe;
	logic next_detect;

	// ******************************
	// Control bundle to the switch driver
	// ******************************
	dac5_if ctl_bus ();

	assign ctl_bus.enable = control[BIT_ENABLE];
	assign ctl_bus.pin_oe = control[BIT_PIN_OE];
	assign ctl_bus.pss = control[BIT_PSS_HI:BIT_PSS_LO];
	assign ctl_bus.negative_source_select = control[BIT_NSS];
	assign ctl_bus.level = level;

	// ******************************
	// Register write and read
	// ******************************
	always_comb begin
		next_control = control;
		next_level = level;
		// Sleep input deliberately not used: contents survive sleep and wake
		if (wr_i && addr_i == ADDR_CONTROL) begin
			next_control = wdata_i & CONTROL_MASK;
		end
		if (wr_i && addr_i == ADDR_LEVEL) begin
			next_level = wdata_i[LEVEL_WIDTH-1:0];
		end
	end

	always_comb begin
		next_rdata = READ_ZERO;
		if (rd_i) begin
			case (addr_i)
				ADDR_CONTROL: next_rdata = control;
				ADDR_LEVEL: next_rdata = {3'h0, level};
				ADDR_PIN: next_rdata = {7'h00, control[BIT_PIN_OE] ? 1'b0 : pin_sync};
				default: next_rdata = {7'h00, sleep_i};
			endcase
		end
	end

	// ******************************
	// Pin override
	// ******************************
	always_comb begin
		next_pin_out = port_out_i;
		next_pin_oe = port_drive_i;
		next_detect = port_detect_en_i;
		if (control[BIT_PIN_OE]) begin
			next_pin_out = 1'b0;
			next_pin_oe = 1'b0;
			next_detect = 1'b0;
		end
	end

	// ******************************
	// State registers
	// ******************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			control <= CONTROL_RESET;
			level <= LEVEL_RESET;
			rdata_o <= READ_ZERO;
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_out_o <= 1'b0;
			pin_oe_o <= 1'b0;
			pin_detect_en_o <= 1'b0;
		end else begin
			control <= next_control;
			level <= next_level;
			rdata_o <= next_rdata;
			pin_meta <= pin_in_i;
			pin_sync <= pin_meta;
			pin_out_o <= next_pin_out;
			pin_oe_o <= next_pin_oe;
			pin_detect_en_o <= next_detect;
		end
	end

	// ******************************
	// Ladder switching
	// ******************************
	dac5_switch u_switch (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ctl(ctl_bus.drive),
		.tap_sel_o(tap_sel_o),
		.pos_sel_o(pos_sel_o),
		.neg_sel_o(neg_sel_o),
		.ladder_on_o(ladder_on_o),
		.pin_connect_o(pin_connect_o),
		.internal_route_o(internal_route_o)
	);

	// ******************************
	// Assertions
	// ******************************
	property p_off;
		@(posedge clk_i) disable iff (!rst_n_i) !control[BIT_ENABLE] |=> (tap_sel_o == '0 && !ladder_on_o);
	endproperty
	a_off: assert property (p_off) else $error("ladder active while disabled");

	property p_tap;
		@(posedge clk_i) disable iff (!rst_n_i) control[BIT_ENABLE] |=> tap_sel_o == (32'h1 << $past(level));
	endproperty
	a_tap: assert property (p_tap) else $error("tap does not match level");

	property p_level_write;
		@(posedge clk_i) disable iff (!rst_n_i)
			(wr_i && addr_i == ADDR_LEVEL && control[BIT_ENABLE]) ##1 control[BIT_ENABLE]
			|=> tap_sel_o == (32'h1 << $past(wdata_i[LEVEL_WIDTH-1:0], 2));
	endproperty
	a_level_write: assert property (p_level_write) else $error("level write not applied directly");

	property p_route;
		@(posedge clk_i) disable iff (!rst_n_i) ##1 internal_route_o == $past(control[BIT_ENABLE]);
	endproperty
	a_route: assert property (p_route) else $error("internal route wrong");

	property p_pin_conn;
		@(posedge clk_i) disable iff (!rst_n_i) $rose(control[BIT_PIN_OE]) |=> pin_connect_o;
	endproperty
	a_pin_conn: assert property (p_pin_conn) else $error("pin not connected");

	property p_override;
		@(posedge clk_i) disable iff (!rst_n_i) control[BIT_PIN_OE] |=> (!pin_oe_o && !pin_out_o && !pin_detect_en_o);
	endproperty
	a_override: assert property (p_override) else $error("pin driver not overridden");

	property p_read_zero;
		@(posedge clk_i) disable iff (!rst_n_i) (rd_i && addr_i == ADDR_PIN && control[BIT_PIN_OE]) |=> rdata_o == READ_ZERO;
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("pin read not zero");

	property p_pos;
		@(posedge clk_i) disable iff (!rst_n_i)
			(control[BIT_ENABLE] && control[BIT_PSS_HI:BIT_PSS_LO] == POS_FIXED_REF) |=> pos_sel_o == 3'h4;
	endproperty
	a_pos: assert property (p_pos) else $error("positive source decode wrong");

	property p_neg;
		@(posedge clk_i) disable iff (!rst_n_i) (control[BIT_ENABLE] && control[BIT_NSS]) |=> neg_sel_o == 2'h2;
	endproperty
	a_neg: assert property (p_neg) else $error("negative source decode wrong");

	property p_mask;
		@(posedge clk_i) disable iff (!rst_n_i) (control & ~CONTROL_MASK) == READ_ZERO;
	endproperty
	a_mask: assert property (p_mask) else $error("unimplemented bit set");

	property p_reset;
		@(posedge clk_i) !rst_n_i |=> (control == CONTROL_RESET && level == LEVEL_RESET);
	endproperty
	a_reset: assert property (p_reset) else $error("reset did not clear control");

	// ******************************
	// Assertions: enable, tap and sleep
	// ******************************
	property p_tap_onehot;
		@(posedge clk_i) disable iff (!rst_n_i) control[BIT_ENABLE] |=> $onehot(tap_sel_o);
	endproperty
	a_tap_onehot: assert property (p_tap_onehot) else $error("tap select not one-hot");

	property p_ladder_on;
		@(posedge clk_i) disable iff (!rst_n_i) control[BIT_ENABLE] |=> (ladder_on_o && internal_route_o);
	endproperty
	a_ladder_on: assert property (p_ladder_on) else $error("ladder not on while enabled");

	property p_off_sources;
		@(posedge clk_i) disable iff (!rst_n_i) !control[BIT_ENABLE] |=> (pos_sel_o == '0 && neg_sel_o == '0);
	endproperty
	a_off_sources: assert property (p_off_sources) else $error("source switch closed while disabled");

	property p_sleep_run;
		@(posedge clk_i) disable iff (!rst_n_i) (control[BIT_ENABLE] && sleep_i) |=> ladder_on_o;
	endproperty
	a_sleep_run: assert property (p_sleep_run) else $error("ladder stopped during sleep");

	// ******************************
	// Assertions: source switches
	// ******************************
	property p_supply;
		@(posedge clk_i) disable iff (!rst_n_i)
			(control[BIT_ENABLE] && control[BIT_PSS_HI:BIT_PSS_LO] == POS_SUPPLY) |=> pos_sel_o == 3'h1;
	endproperty
	a_supply: assert property (p_supply) else $error("supply source decode wrong");

	property p_ref_pin;
		@(posedge clk_i) disable iff (!rst_n_i)
			(control[BIT_ENABLE] && control[BIT_PSS_HI:BIT_PSS_LO] == POS_REF_PIN) |=> pos_sel_o == 3'h2;
	endproperty
	a_ref_pin: assert property (p_ref_pin) else $error("reference pin source decode wrong");

	property p_reserved;
		@(posedge clk_i) disable iff (!rst_n_i)
			(control[BIT_ENABLE] && control[BIT_PSS_HI:BIT_PSS_LO] == POS_RESERVED) |=> pos_sel_o == '0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved source code closed a switch");

	property p_ground;
		@(posedge clk_i) disable iff (!rst_n_i)
			(control[BIT_ENABLE] && !control[BIT_NSS]) |=> neg_sel_o == 2'h1;
	endproperty
	a_ground: assert property (p_ground) else $error("ground source decode wrong");

	// ******************************
	// Assertions: analog pin
	// ******************************
	property p_pin_off;
		@(posedge clk_i) disable iff (!rst_n_i) !control[BIT_PIN_OE] |=> !pin_connect_o;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin still connected");

	// Sampled reset in the antecedent skips the edge on which reset is released
	property p_pin_free;
		@(posedge clk_i) disable iff (!rst_n_i) (rst_n_i && !control[BIT_PIN_OE]) |=> (pin_out_o == $past(port_out_i)
			&& pin_oe_o == $past(port_drive_i) && pin_detect_en_o == $past(port_detect_en_i));
	endproperty
	a_pin_free: assert property (p_pin_free) else $error("port signals not passed while pin digital");

	property p_read_live;
		@(posedge clk_i) disable iff (!rst_n_i)
			(rst_n_i && rd_i && addr_i == ADDR_PIN && !control[BIT_PIN_OE]) |=> rdata_o == {7'h00, $past(pin_sync)};
	endproperty
	a_read_live: assert property (p_read_live) else $error("pin read not live while pin digital");

	// ******************************
	// Assertions: registers and reset
	// ******************************
	property p_control_write;
		@(posedge clk_i) disable iff (!rst_n_i)
			(wr_i && addr_i == ADDR_CONTROL) |=> control == ($past(wdata_i) & CONTROL_MASK);
	endproperty
	a_control_write: assert property (p_control_write) else $error("control write not masked");

	property p_level_direct;
		@(posedge clk_i) disable iff (!rst_n_i)
			(wr_i && addr_i == ADDR_LEVEL) |=> level == $past(wdata_i[LEVEL_WIDTH-1:0]);
	endproperty
	a_level_direct: assert property (p_level_direct) else $error("level write not taken at once");

	property p_control_read;
		@(posedge clk_i) disable iff (!rst_n_i)
			(rd_i && addr_i == ADDR_CONTROL) |=> (rdata_o == $past(control) && (rdata_o & ~CONTROL_MASK) == READ_ZERO);
	endproperty
	a_control_read: assert property (p_control_read) else $error("control read wrong");

	property p_level_read;
		@(posedge clk_i) disable iff (!rst_n_i)
			(rd_i && addr_i == ADDR_LEVEL) |=> (rdata_o & ~LEVEL_MASK) == READ_ZERO;
	endproperty
	a_level_read: assert property (p_level_read) else $error("level read shows unused bits");

	property p_hold;
		@(posedge clk_i) disable iff (!rst_n_i) !(wr_i && addr_i == ADDR_CONTROL) |=> $stable(control);
	endproperty
	a_hold: assert property (p_hold) else $error("control changed without a write");

	property p_level_hold;
		@(posedge clk_i) disable iff (!rst_n_i) !(wr_i && addr_i == ADDR_LEVEL) |=> $stable(level);
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level changed without a write");

	property p_reset_outputs;
		@(posedge clk_i) !rst_n_i |=> (!pin_connect_o && !ladder_on_o && tap_sel_o == '0);
	endproperty
	a_reset_outputs: assert property (p_reset_outputs) else $error("reset left ladder or pin active");
endmodule : dac5_ctrl

// ### dv/dac5_ctrl_bench.sv
// Self-checking bench of the 5-bit converter control
`timescale 1ns/1ps
module dac5_ctrl_bench;
	import dac5_pkg::*;
	logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, sleep_i = 0, pin_in_i = 1;
	logic port_out_i = 1, port_drive_i = 1, port_detect_en_i = 1;
	logic [1:0] addr_i = 2'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o, d;
	logic pin_out_o, pin_oe_o, pin_detect_en_o, ladder_on_o, pin_connect_o, internal_route_o;
	logic [31:0] tap_sel_o;
	logic [2:0] pos_sel_o;
	logic [1:0] neg_sel_o;
	int err_count = 0, checks = 0;

	dac5_ctrl i_dac5_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .port_out_i(port_out_i), .port_drive_i(port_drive_i),
		.port_detect_en_i(port_detect_en_i), .pin_in_i(pin_in_i), .sleep_i(sleep_i), .pin_out_o(pin_out_o),
		.pin_oe_o(pin_oe_o), .pin_detect_en_o(pin_detect_en_o), .tap_sel_o(tap_sel_o), .pos_sel_o(pos_sel_o),
		.neg_sel_o(neg_sel_o), .ladder_on_o(ladder_on_o), .pin_connect_o(pin_connect_o),
		.internal_route_o(internal_route_o));

	initial forever #5 clk_i = ~clk_i;

	// ******************************
	// Bus and compare tasks
	// ******************************
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Returns once the switch outputs show the write
	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1;
		@(posedge clk_i);
		wr_i <= 0;
		@(posedge clk_i);
		#1;
	endtask : wr

	task rd(input logic [1:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1;
		@(posedge clk_i);
		rd_i <= 0;
		#1 d = rdata_o;
	endtask : rd

	// ******************************
	// Scenarios
	// ******************************
	task t_reset;
		wr(ADDR_LEVEL, 8'h05);
		wr(ADDR_CONTROL, 8'hA0);
		@(posedge clk_i);
		rst_n_i <= 0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1;
		@(posedge clk_i);
		#1 chk("pin_connect", 0, pin_connect_o);
		chk("ladder_on", 0, ladder_on_o);
		rd(ADDR_CONTROL);
		chk("control", 0, d);
		rd(ADDR_LEVEL);
		chk("level", 0, d);
	endtask : t_reset

	task t_mask;
		wr(ADDR_CONTROL, 8'hFF);
		wr(ADDR_LEVEL, 8'hFF);
		wr(ADDR_STATUS, 8'h00);
		wr(ADDR_PIN, 8'h00);
		rd(ADDR_CONTROL);
		chk("control", 8'hAD, d);
		rd(ADDR_LEVEL);
		chk("level", 8'h1F, d);
	endtask : t_mask

	task t_levels;
		wr(ADDR_CONTROL, 8'h80);
		for (int i = 0; i < 32; i++) begin
			wr(ADDR_LEVEL, 8'(i));
			chk("tap", 32'h1 << i, tap_sel_o);
		end
		chk("route", 1, internal_route_o);
		chk("ladder_on", 1, ladder_on_o);
		wr(ADDR_CONTROL, 8'h00);
		chk("ladder_off", 0, ladder_on_o);
		chk("tap_off", 0, tap_sel_o);
	endtask : t_levels

	task t_sources;
		for (int p = 0; p < 4; p++) begin
			for (int n = 0; n < 2; n++) begin
				wr(ADDR_CONTROL, 8'h80 | 8'(p << 2) | 8'(n));
				chk("pos", (p == 3) ? 0 : (1 << p), pos_sel_o);
				chk("neg", 1 << n, neg_sel_o);
			end
		end
	endtask : t_sources

	task t_pin;
		wr(ADDR_CONTROL, 8'h20);
		chk("pin_connect", 1, pin_connect_o);
		chk("pin_drive", 0, {pin_oe_o, pin_out_o, pin_detect_en_o});
		rd(ADDR_PIN);
		chk("pin_read", 0, d);
		wr(ADDR_CONTROL, 8'h00);
		chk("pin_free", 0, pin_connect_o);
		chk("pin_drive", 3'h7, {pin_oe_o, pin_out_o, pin_detect_en_o});
		rd(ADDR_PIN);
		chk("pin_live", 1, d);
	endtask : t_pin

	task t_sleep;
		wr(ADDR_CONTROL, 8'hA4);
		@(posedge clk_i);
		sleep_i <= 1;
		repeat (4) @(posedge clk_i);
		#1 chk("sleep_run", 1, ladder_on_o);
		rd(ADDR_STATUS);
		chk("status", 1, d);
		@(posedge clk_i);
		sleep_i <= 0;
		rd(ADDR_CONTROL);
		chk("wake", 8'hA4, d);
	endtask : t_sleep

	task print_verdict;
		if (err_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1;
		t_mask();
		t_levels();
		t_sources();
		t_pin();
		t_sleep();
		t_reset();
		print_verdict();
	end

	initial begin
		repeat (3000) @(posedge clk_i);
		err_count++;
		print_verdict();
	end
endmodule : dac5_ctrl_bench
